//--- aos_defs.vh
// Constants for the analog output sequencer: register map, fields, timing.
// Assumes a 125 MHz hclk; included by aos_top.v.
// Functional notes
// R1 - Sampling starts either on a software start command or on an external start trigger.
// R2 - Sampling ends after a programmed sample count, on an external stop trigger, or by software.
// R3 - Each sampling period is paced by the internal clock or by an external sampling clock.
// R4 - Samples sit in a 1K-word buffer that software runs either as a FIFO or as a ring.
// R5 - Software picks the rising or the falling edge for external start, stop and clock inputs.
// R6 - A 1 us noise filter can be switched on or off for the start and stop inputs separately.
// R7 - The external sampling clock and the counter gate input pass with no noise filter.
// R8 - The noise filter also serves the digital input lines and the counter count input.
// R9 - Four 16-bit channels are driven, with at most one conversion every 10 us.
// R10 - After reset every channel holds the code for 0 V until software data arrives.
// R11 - With the filter on, a new input level counts only after staying stable the whole interval.
// R12 - Ring mode replays the buffer cyclically; FIFO mode consumes each sample once.
`ifndef AOS_DEFS_VH
`define AOS_DEFS_VH

`define AOS_CLK_NS        8
`define AOS_FILT_NS       1000
`define AOS_FILT_CYC      ((`AOS_FILT_NS + `AOS_CLK_NS - 1) / `AOS_CLK_NS)
`define AOS_CONV_NS       10000
`define AOS_CONV_CYC      ((`AOS_CONV_NS + `AOS_CLK_NS - 1) / `AOS_CLK_NS)

`define AOS_BUF_DEPTH     1024
`define AOS_NCH           4
`define AOS_CODE_ZERO     16'h8000

`define AOS_OFF_CTRL      8'h00
`define AOS_OFF_CMD       8'h04
`define AOS_OFF_STATUS    8'h08
`define AOS_OFF_DATA      8'h0C
`define AOS_OFF_PERIOD    8'h10
`define AOS_OFF_COUNT     8'h14
`define AOS_OFF_DONE      8'h18
`define AOS_OFF_DIN       8'h1C

`define AOS_CTRL_RING     0
`define AOS_CTRL_STARTEXT 1
`define AOS_CTRL_STOPLO   2
`define AOS_CTRL_STOPHI   3
`define AOS_CTRL_CLKEXT   4
`define AOS_CTRL_STARTFE  5
`define AOS_CTRL_STOPFE   6
`define AOS_CTRL_CLKFE    7
`define AOS_CTRL_STARTFLT 8
`define AOS_CTRL_STOPFLT  9
`define AOS_CTRL_DINFLT   10
`define AOS_CTRL_CNTFLT   11
`define AOS_CTRL_W        12
`define AOS_CTRL_RST      12'h000

`define AOS_STOP_COUNT    2'h0
`define AOS_STOP_EXT      2'h1
`define AOS_STOP_SW       2'h2

`define AOS_CMD_START     0
`define AOS_CMD_STOP      1
`define AOS_CMD_CLEAR     2

`define AOS_PERIOD_RST    32'h000004E2
`define AOS_COUNT_RST     32'h00000001

`endif

//--- aos_top.v
// Analog output sequencer: AHB-Lite slave, 1K sample buffer, trigger and
// pacing logic, four 16-bit channel outputs. Assumes synchronous AHB master
// on hclk; external pins are asynchronous and synchronised here.
`timescale 1ns/100ps
`include "aos_defs.vh"

module aos_top #(
   parameter DEPTH    = `AOS_BUF_DEPTH,
   parameter AW       = 10,
   parameter FILT_CYC = `AOS_FILT_CYC,
   parameter CONV_CYC = `AOS_CONV_CYC
) (
   input  wire        hclk,
   input  wire        hresetn,
   input  wire        hsel,
   input  wire [31:0] haddr,
   input  wire [1:0]  htrans,
   input  wire        hwrite,
   input  wire [2:0]  hsize,
   input  wire [31:0] hwdata,
   input  wire        hready,
   output wire [31:0] hrdata,
   output wire        hreadyout,
   output wire        hresp,
   input  wire        ext_start,
   input  wire        ext_stop,
   input  wire        ext_clk,
   input  wire [3:0]  din,
   input  wire        cnt_up,
   input  wire        cnt_gate,
   output wire [15:0] dac_code0,
   output wire [15:0] dac_code1,
   output wire [15:0] dac_code2,
   output wire [15:0] dac_code3,
   output wire        dac_load,
   output wire        busy,
   output wire [3:0]  din_level,
   output wire        cnt_up_level,
   output wire        cnt_gate_level
);

   localparam ST_IDLE  = 2'h0;
   localparam ST_ARMED = 2'h1;
   localparam ST_RUN   = 2'h2;
   localparam ST_LOAD  = 2'h3;
   localparam NIN      = 9;
   localparam [31:0] FILT_LAST = FILT_CYC - 1;
   localparam [31:0] CONV_MIN = CONV_CYC;

   // Register bus
   reg [31:0]            hrdata_reg;
   reg                   wr_pend_reg;
   reg [7:0]             wr_addr_reg;
   reg [`AOS_CTRL_W-1:0] ctrl_reg;
   reg [31:0]            period_reg;
   reg [31:0]            count_reg;
   reg [31:0]            done_reg;
   reg                   underrun_reg;
   // Buffer
   reg [15:0]            mem [0:DEPTH-1];
   reg [AW-1:0]          wr_ptr_reg;
   reg [AW-1:0]          rd_ptr_reg;
   reg [AW:0]            fill_reg;
   // Sequencer
   reg [1:0]             state_reg;
   reg [1:0]             ch_reg;
   reg [63:0]            codes_reg;
   reg                   load_reg;
   reg [31:0]            div_reg;
   reg [31:0]            gap_reg;
   reg                   stop_pend_reg;
   // Pins
   wire [NIN-1:0]        filt_w;
   wire [NIN-1:0]        prev_w;

   wire [NIN-1:0] pins = {cnt_gate, ext_clk, cnt_up, din, ext_stop, ext_start};
   wire [NIN-1:0] flt_en = {1'b0, 1'b0,                         // R7
                            ctrl_reg[`AOS_CTRL_CNTFLT],         // R8
                            {4{ctrl_reg[`AOS_CTRL_DINFLT]}},    // R8
                            ctrl_reg[`AOS_CTRL_STOPFLT],        // R6
                            ctrl_reg[`AOS_CTRL_STARTFLT]};      // R6

   function edge_hit;
      input now_lvl;
      input old_lvl;
      input falling;
      begin
         edge_hit = falling ? (old_lvl & ~now_lvl) : (~old_lvl & now_lvl);
      end
   endfunction

   // Synchroniser and noise filter per input
   genvar gi;
   generate
      for (gi = 0; gi < NIN; gi = gi + 1) begin : g_in
         reg       s1_reg, s2_reg, s3_reg, lvl_reg, filt_reg, prev_reg;
         reg [6:0] cnt_reg;
         always @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               s1_reg   <= 1'b0;
               s2_reg   <= 1'b0;
               s3_reg   <= 1'b0;
               lvl_reg  <= 1'b0;
               filt_reg <= 1'b0;
               prev_reg <= 1'b0;
               cnt_reg  <= 7'h00;
            end else begin
               s1_reg   <= pins[gi];
               s2_reg   <= s1_reg;
               s3_reg   <= s2_reg;
               if (s2_reg == s3_reg) begin
                  lvl_reg <= s3_reg;
               end
               prev_reg <= filt_reg;
               if (!flt_en[gi]) begin
                  filt_reg <= lvl_reg;
                  cnt_reg  <= 7'h00;
               end else if (lvl_reg == filt_reg) begin
                  cnt_reg  <= 7'h00;
               end else if (cnt_reg == FILT_LAST[6:0]) begin
                  filt_reg <= lvl_reg; // R11
                  cnt_reg  <= 7'h00;
               end else begin
                  cnt_reg  <= cnt_reg + 7'h01;
               end
            end
         end
         assign filt_w[gi] = filt_reg;
         assign prev_w[gi] = prev_reg;
      end
   endgenerate

   wire start_edge = edge_hit(filt_w[0], prev_w[0], ctrl_reg[`AOS_CTRL_STARTFE]); // R5
   wire stop_edge  = edge_hit(filt_w[1], prev_w[1], ctrl_reg[`AOS_CTRL_STOPFE]);  // R5
   wire clk_edge   = edge_hit(filt_w[7], prev_w[7], ctrl_reg[`AOS_CTRL_CLKFE]);   // R5

   // Bus decode
   wire        addr_ok = hsel & htrans[1] & hready;
   wire        wr_now  = wr_pend_reg;
   wire        cmd_wr  = wr_now && (wr_addr_reg == `AOS_OFF_CMD);
   wire        sw_start = cmd_wr & hwdata[`AOS_CMD_START];
   wire        sw_stop  = cmd_wr & hwdata[`AOS_CMD_STOP];
   wire        clr      = cmd_wr & hwdata[`AOS_CMD_CLEAR];
   wire        ring     = ctrl_reg[`AOS_CTRL_RING];
   wire [1:0]  stop_src = ctrl_reg[`AOS_CTRL_STOPHI:`AOS_CTRL_STOPLO];
   wire [31:0] depth_w  = DEPTH;
   wire        full     = (fill_reg == depth_w[AW:0]);
   wire        busy_w   = (state_reg != ST_IDLE);
   wire        empty    = (fill_reg == {(AW+1){1'b0}});
   wire        push     = wr_now && (wr_addr_reg == `AOS_OFF_DATA) && !full && !clr;

   // Pacing: internal divider or external clock, spaced at least 10 us
   wire [31:0] per_eff = (period_reg < CONV_MIN) ? CONV_MIN : period_reg;  // R9
   wire        int_tick = (div_reg >= per_eff - 32'h1);
   wire        raw_tick = ctrl_reg[`AOS_CTRL_CLKEXT] ? clk_edge : int_tick;  // R3
   wire        tick = raw_tick && (gap_reg == 32'h0) && (state_reg == ST_RUN); // R9
   wire        pop  = (state_reg == ST_LOAD) && !empty;

   wire [AW-1:0] rd_inc = rd_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
   wire          ring_wrap = ({1'b0, rd_inc} == fill_reg) || (rd_inc == {AW{1'b0}});
   wire          stop_now = sw_stop                                          // R2
                 || (stop_src == `AOS_STOP_EXT && stop_edge)                 // R2
                 || (stop_src == `AOS_STOP_COUNT && done_reg >= count_reg);  // R2

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
         hrdata_reg  <= 32'h00000000;
      end else begin
         wr_pend_reg <= addr_ok & hwrite;
         if (addr_ok) begin
            wr_addr_reg <= haddr[7:0];
         end
         if (addr_ok && !hwrite) begin
            if (haddr[7:0] == `AOS_OFF_CTRL) begin
               hrdata_reg <= {{(32-`AOS_CTRL_W){1'b0}}, ctrl_reg};
            end else if (haddr[7:0] == `AOS_OFF_STATUS) begin
               hrdata_reg <= {5'h00, fill_reg, 12'h000,
                              underrun_reg, full, empty, busy_w};
            end else if (haddr[7:0] == `AOS_OFF_PERIOD) begin
               hrdata_reg <= period_reg;
            end else if (haddr[7:0] == `AOS_OFF_COUNT) begin
               hrdata_reg <= count_reg;
            end else if (haddr[7:0] == `AOS_OFF_DONE) begin
               hrdata_reg <= done_reg;
            end else if (haddr[7:0] == `AOS_OFF_DIN) begin
               hrdata_reg <= {26'h0000000, filt_w[8], filt_w[6:2]}; // R8
            end else begin
               hrdata_reg <= 32'h00000000;
            end
         end
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_reg   <= `AOS_CTRL_RST;
         period_reg <= `AOS_PERIOD_RST;
         count_reg  <= `AOS_COUNT_RST;
      end else if (wr_now && !busy_w) begin
         if (wr_addr_reg == `AOS_OFF_CTRL) begin
            ctrl_reg <= hwdata[`AOS_CTRL_W-1:0];
         end else if (wr_addr_reg == `AOS_OFF_PERIOD) begin
            period_reg <= hwdata;
         end else if (wr_addr_reg == `AOS_OFF_COUNT) begin
            count_reg <= hwdata;
         end
      end
   end

   // Buffer memory
   always @(posedge hclk) begin
      if (push) begin
         mem[wr_ptr_reg] <= hwdata[15:0]; // R4
      end
   end

   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_ptr_reg <= {AW{1'b0}};
         rd_ptr_reg <= {AW{1'b0}};
         fill_reg   <= {(AW+1){1'b0}};
      end else if (clr) begin
         wr_ptr_reg <= {AW{1'b0}};
         rd_ptr_reg <= {AW{1'b0}};
         fill_reg   <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr_reg <= wr_ptr_reg + {{(AW-1){1'b0}}, 1'b1};
         end
         if (pop && ring) begin
            rd_ptr_reg <= ring_wrap ? {AW{1'b0}} : rd_inc; // R12
         end else if (pop) begin
            rd_ptr_reg <= rd_inc; // R12
         end
         if (push && !(pop && !ring)) begin
            fill_reg <= fill_reg + {{AW{1'b0}}, 1'b1};
         end else if (!push && pop && !ring) begin
            fill_reg <= fill_reg - {{AW{1'b0}}, 1'b1}; // R12
         end
      end
   end

   // Sequencer
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_reg    <= ST_IDLE;
         ch_reg       <= 2'h0;
         codes_reg    <= {`AOS_NCH{`AOS_CODE_ZERO}}; // R10
         load_reg     <= 1'b0;
         div_reg      <= 32'h0;
         gap_reg      <= 32'h0;
         done_reg     <= 32'h0;
         underrun_reg <= 1'b0;
         stop_pend_reg <= 1'b0;
      end else begin
         load_reg <= 1'b0;
         stop_pend_reg <= (state_reg == ST_LOAD) && (stop_pend_reg || stop_now); // R2
         div_reg  <= (state_reg != ST_RUN || int_tick) ? 32'h0 : div_reg + 32'h1;
         if (tick) begin
            gap_reg <= CONV_MIN - 32'h1; // R9
         end else if (gap_reg != 32'h0) begin
            gap_reg <= gap_reg - 32'h1;
         end
         if (clr) begin
            underrun_reg <= 1'b0;
         end
         case (state_reg)
            ST_IDLE: begin
               ch_reg <= 2'h0;
               if (sw_start) begin
                  done_reg     <= 32'h0;
                  underrun_reg <= 1'b0;
                  state_reg    <= ctrl_reg[`AOS_CTRL_STARTEXT] ? ST_ARMED : ST_RUN; // R1
               end
            end
            ST_ARMED: begin
               if (sw_stop) begin
                  state_reg <= ST_IDLE;
               end else if (start_edge) begin
                  state_reg <= ST_RUN; // R1
               end
            end
            ST_RUN: begin
               if (stop_now || stop_pend_reg) begin
                  state_reg <= ST_IDLE; // R2
               end else if (tick) begin
                  state_reg <= ST_LOAD;
               end
            end
            ST_LOAD: begin
               if (empty) begin
                  underrun_reg <= 1'b1;
                  state_reg    <= ST_IDLE;
               end else begin
                  codes_reg[ch_reg*16 +: 16] <= mem[rd_ptr_reg]; // R9
                  ch_reg <= ch_reg + 2'h1;
                  if (ch_reg == 2'h3) begin
                     load_reg  <= 1'b1;
                     done_reg  <= done_reg + 32'h1;
                     state_reg <= ST_RUN;
                  end
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   reg        busy_reg;
   reg [5:0]  lvl_out_reg;
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         busy_reg    <= 1'b0;
         lvl_out_reg <= 6'h00;
      end else begin
         busy_reg    <= busy_w;
         lvl_out_reg <= {filt_w[8], filt_w[6:2]};
      end
   end

   assign hrdata         = hrdata_reg;
   assign hreadyout      = 1'b1;
   assign hresp          = 1'b0;
   assign dac_code0      = codes_reg[15:0];
   assign dac_code1      = codes_reg[31:16];
   assign dac_code2      = codes_reg[47:32];
   assign dac_code3      = codes_reg[63:48];
   assign dac_load       = load_reg;
   assign busy           = busy_reg;
   assign din_level      = lvl_out_reg[3:0];
   assign cnt_up_level   = lvl_out_reg[4];
   assign cnt_gate_level = lvl_out_reg[5];

endmodule // aos_top

//--- aos_checker.sv
// Port checker for the analog output sequencer.
// Bound to every aos_top instance; sees only its ports.
`timescale 1ns/100ps
module aos_checker #(
   parameter CONV_CYC = 1250
) (
   input wire        hclk,
   input wire        hresetn,
   input wire        hsel,
   input wire [1:0]  htrans,
   input wire        hwrite,
   input wire        hready,
   input wire [31:0] hrdata,
   input wire        hreadyout,
   input wire        hresp,
   input wire        cnt_gate,
   input wire        cnt_gate_level,
   input wire [15:0] dac_code0,
   input wire [15:0] dac_code1,
   input wire [15:0] dac_code2,
   input wire [15:0] dac_code3,
   input wire        dac_load,
   input wire        busy
);
   reg [15:0] gap_reg;
   reg        seen_reg;

   // Cycles since the last sample load
   always @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         gap_reg  <= 16'h0000;
         seen_reg <= 1'b0;
      end else if (dac_load) begin
         gap_reg  <= 16'h0000;
         seen_reg <= 1'b1;
      end else if (gap_reg != 16'hFFFF) begin
         gap_reg <= gap_reg + 16'h0001;
      end
   end

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   a_resp_okay: assert property (hreadyout && !hresp)
      else $error("bus answer is not zero-wait OKAY");
   a_rdata_hold: assert property (!$past(hsel && htrans[1] && !hwrite && hready)
      |-> $stable(hrdata)) else $error("read data moved without a read");
   a_code_reset: assert property ($rose(hresetn) |->
      {dac_code0, dac_code1, dac_code2, dac_code3} == {4{16'h8000}})
      else $error("channel code not mid-scale after reset");
   a_code_load: assert property ($changed(dac_code0) |-> ##[0:5] dac_load)
      else $error("channel code changed without a load pulse");
   a_load_pulse: assert property (dac_load |=> !dac_load)
      else $error("load pulse longer than one cycle");
   a_load_gap: assert property (dac_load && seen_reg |-> gap_reg >= CONV_CYC - 1)
      else $error("samples loaded faster than the conversion time");
   a_load_busy: assert property (dac_load |-> busy)
      else $error("sample loaded while idle");
   a_gate_high: assert property (cnt_gate [*8] |-> cnt_gate_level)
      else $error("gate level missed a steady high");
   a_gate_low: assert property (!cnt_gate [*8] |-> !cnt_gate_level)
      else $error("gate level missed a steady low");
endmodule // aos_checker

bind aos_top aos_checker #(.CONV_CYC(CONV_CYC)) i_aos_checker (.hclk, .hresetn, .hsel,
   .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp, .cnt_gate, .cnt_gate_level,
   .dac_code0, .dac_code1, .dac_code2, .dac_code3, .dac_load, .busy);

//--- aos_pin_src.sv
// External sampling clock source on the ext_clk pin.
// Runs on its own time base, unrelated to hclk.
`timescale 1ns/100ps
module aos_pin_src #(
   parameter HALF_NS = 50
) (
   input  wire run,
   output reg  ext_clk
);
   // Stands low between frames, clean edges
   initial ext_clk = 1'b0;
   always begin
      #(HALF_NS);
      ext_clk = run ? ~ext_clk : 1'b0;
   end
endmodule // aos_pin_src

//--- analog_output_sequencer_tb_top.sv
// Self-checking bench for the analog output sequencer.
// Drives aos_top over AHB-Lite and its pins; short filter and conversion counts.
`timescale 1ns/100ps
`include "aos_defs.vh"
module analog_output_sequencer_tb_top;
   reg         hclk = 1'b0, hresetn = 1'b0, hsel = 1'b1, hwrite = 1'b0;
   reg         ext_start = 1'b1, ext_stop = 1'b1, src_run = 1'b0, cnt_up = 1'b0, cnt_gate = 1'b0;
   reg  [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
   reg  [1:0]  htrans = 2'h0;
   reg  [2:0]  hsize = 3'h2;
   reg  [3:0]  din = 4'h0;
   reg  [5:0]  acc;
   wire [31:0] hrdata;
   wire        hreadyout, hresp, ext_clk, dac_load, busy, cnt_up_level, cnt_gate_level;
   wire [15:0] dac_code0, dac_code1, dac_code2, dac_code3;
   wire [3:0]  din_level;
   integer     error_cnt = 0, samples_checked = 0, cyc = 0, i, n;

   aos_top #(.FILT_CYC(4), .CONV_CYC(8)) i_aos_top (.hclk, .hresetn, .hsel, .haddr, .htrans,
      .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .ext_start,
      .ext_stop, .ext_clk, .din, .cnt_up, .cnt_gate, .dac_code0, .dac_code1, .dac_code2,
      .dac_code3, .dac_load, .busy, .din_level, .cnt_up_level, .cnt_gate_level);
   aos_pin_src #(.HALF_NS(50)) i_aos_pin_src (.run(src_run), .ext_clk);

   always #4 hclk = ~hclk;
   always @(posedge hclk) begin
      cyc = cyc + 1;
      if (cyc == 60000) begin
         error_cnt = error_cnt + 1;
         end_of_test;
      end
   end

   task end_of_test;
      begin
         $display("checks %0d mismatches %0d", samples_checked, error_cnt);
         if (error_cnt == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
         end else begin
            $display("Finished with errors");
         end
         $finish;
      end
   endtask

   task chk(input [31:0] exp, input [31:0] got);
      begin
         samples_checked = samples_checked + 1;
         if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("[ERR] t=%0t exp=%h got=%h", $time, exp, got);
         end
      end
   endtask

   task xfer(input w, input [7:0] a, input [31:0] d);
      begin
         @(posedge hclk);
         htrans <= 2'h2;
         haddr  <= {24'h000000, a};
         hwrite <= w;
         @(posedge hclk);
         while (hreadyout !== 1'b1) @(posedge hclk);
         htrans <= 2'h0;
         hwdata <= d;
         @(posedge hclk);
         while (hreadyout !== 1'b1) @(posedge hclk);
         rd = hrdata;
      end
   endtask

   task wr(input [7:0] a, input [31:0] d);
      xfer(1'b1, a, d);
   endtask

   task rdchk(input [7:0] a, input [31:0] exp);
      begin
         xfer(1'b0, a, 32'h0);
         chk(exp, rd);
      end
   endtask

   task fill(input [15:0] b, input integer cnt);
      for (i = 0; i < cnt; i = i + 1) wr(`AOS_OFF_DATA, {16'h0000, b + i[15:0]});
   endtask

   task wait_load;
      begin
         n = 0;
         @(posedge hclk);
         while (dac_load !== 1'b1 && n < 400) begin
            @(posedge hclk);
            n = n + 1;
         end
         chk(32'h1, {31'h0, dac_load});
      end
   endtask

   task wait_idle;
      begin
         n = 0;
         while (busy !== 1'b0 && n < 400) begin
            @(posedge hclk);
            n = n + 1;
         end
         chk(32'h0, {31'h0, busy});
      end
   endtask

   task chk_sample(input [15:0] b);
      begin
         chk({b, b + 16'h0001}, {dac_code0, dac_code1});
         chk({b + 16'h0002, b + 16'h0003}, {dac_code2, dac_code3});
      end
   endtask

   task pins(input [5:0] v);
      {cnt_gate, cnt_up, din} <= v;
   endtask

   task t_reset;
      begin
         chk({2{`AOS_CODE_ZERO}}, {dac_code0, dac_code1});
         chk({2{`AOS_CODE_ZERO}}, {dac_code2, dac_code3});
         rdchk(`AOS_OFF_CTRL, 32'h0);
         rdchk(`AOS_OFF_STATUS, 32'h2);
         rdchk(`AOS_OFF_PERIOD, `AOS_PERIOD_RST);
         rdchk(`AOS_OFF_COUNT, `AOS_COUNT_RST);
         wr(8'h20, 32'hFFFFFFFF);
         rdchk(8'h20, 32'h0);
         $display("test reset done");
      end
   endtask

   task t_fifo;
      begin
         wr(`AOS_OFF_CMD, 32'h4);
         fill(16'h1000, 8);
         wr(`AOS_OFF_PERIOD, 32'h0);
         wr(`AOS_OFF_COUNT, 32'h2);
         wr(`AOS_OFF_CMD, 32'h1);
         wait_load;
         chk_sample(16'h1000);
         wait_load;
         chk_sample(16'h1004);
         wait_idle;
         rdchk(`AOS_OFF_STATUS, 32'h2);
         rdchk(`AOS_OFF_DONE, 32'h2);
         $display("test fifo done");
      end
   endtask

   task t_ring;
      begin
         wr(`AOS_OFF_CMD, 32'h4);
         fill(16'h2000, 4);
         wr(`AOS_OFF_COUNT, 32'h1);
         wr(`AOS_OFF_CTRL, 32'h9);
         wr(`AOS_OFF_CMD, 32'h1);
         wr(`AOS_OFF_PERIOD, 32'h5);
         repeat (3) begin
            wait_load;
            chk_sample(16'h2000);
         end
         wr(`AOS_OFF_CMD, 32'h2);
         wait_idle;
         rdchk(`AOS_OFF_STATUS, 32'h00040000);
         rdchk(`AOS_OFF_PERIOD, 32'h0);
         $display("test ring done");
      end
   endtask

   task t_full;
      begin
         fill(16'h0000, 1025);
         rdchk(`AOS_OFF_STATUS, 32'h04000004);
         wr(`AOS_OFF_CMD, 32'h4);
         rdchk(`AOS_OFF_STATUS, 32'h2);
         $display("test full done");
      end
   endtask

   task t_ext;
      begin
         fill(16'h3000, 4);
         wr(`AOS_OFF_CTRL, 32'h3F7);
         wr(`AOS_OFF_CMD, 32'h1);
         src_run   <= 1'b1;
         ext_start <= 1'b0;
         repeat (3) @(posedge hclk);
         ext_start <= 1'b1;
         acc = 6'h00;
         repeat (60) @(posedge hclk) acc[0] = acc[0] | dac_load;
         chk(32'h0, {31'h0, acc[0]});
         ext_start <= 1'b0;
         wait_load;
         chk_sample(16'h3000);
         ext_stop <= 1'b0;
         repeat (3) @(posedge hclk);
         ext_stop <= 1'b1;
         wait_load;
         ext_stop <= 1'b0;
         wait_idle;
         src_run <= 1'b0;
         $display("test external done");
      end
   endtask

   task t_levels;
      begin
         wr(`AOS_OFF_CTRL, 32'hC00);
         pins(6'h3F);
         repeat (3) @(posedge hclk);
         pins(6'h00);
         acc = 6'h00;
         repeat (20) @(posedge hclk) acc = acc | {cnt_gate_level, cnt_up_level, din_level};
         chk(32'h20, {26'h0, acc});
         pins(6'h3F);
         repeat (20) @(posedge hclk);
         rdchk(`AOS_OFF_DIN, 32'h3F);
         $display("test levels done");
      end
   endtask

   task t_rise;
      begin
         wr(`AOS_OFF_CMD, 32'h4);
         fill(16'h4000, 4);
         wr(`AOS_OFF_CTRL, 32'h17);
         wr(`AOS_OFF_CMD, 32'h1);
         src_run <= 1'b1;
         acc = 6'h00;
         repeat (40) @(posedge hclk) acc[0] = acc[0] | dac_load;
         chk(32'h0, {31'h0, acc[0]});
         ext_start <= 1'b1;
         wait_load;
         chk_sample(16'h4000);
         ext_stop <= 1'b1;
         wait_idle;
         src_run <= 1'b0;
         $display("test rising done");
      end
   endtask

   initial begin
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      t_reset;
      t_fifo;
      t_ring;
      t_full;
      t_ext;
      t_levels;
      t_rise;
      end_of_test;
   end
endmodule // analog_output_sequencer_tb_top
